// ==== hdl/ihc_top.sv ====
// Purpose: Interrupt request, enable, priority and pause control for three sources.
// Assumes: Core pulses INSTR_END at the end of each instruction cycle with its operation.
// Notes:   Registers reached over AXI4-Lite; all outputs are registered.
`timescale 1ns/1ps
module ihc_top
#(
  parameter int PC_W        = 12,
  parameter int STACK_DEPTH = 3
)
(
  // Clock and reset
  input  wire logic                 CLK,
  input  wire logic                 NRST,
  // AXI4-Lite write channels
  input  wire logic [3:0]           AWADDR,
  input  wire logic                 AWVALID,
  output logic                      AWREADY,
  input  wire logic [31:0]          WDATA,
  input  wire logic [3:0]           WSTRB,
  input  wire logic                 WVALID,
  output logic                      WREADY,
  output logic [1:0]                BRESP,
  output logic                      BVALID,
  input  wire logic                 BREADY,
  // AXI4-Lite read channels
  input  wire logic [3:0]           ARADDR,
  input  wire logic                 ARVALID,
  output logic                      ARREADY,
  output logic [31:0]               RDATA,
  output logic [1:0]                RRESP,
  output logic                      RVALID,
  input  wire logic                 RREADY,
  // Core instruction sequencer
  input  wire logic                 INSTR_END,
  input  wire ihc_pkg::ihc_op_e     INSTR_OP,
  input  wire logic                 INSTR_TWO,
  input  wire logic [3:0]           HALT_OPND,
  input  wire logic [PC_W-1:0]      NEXT_PC,
  output logic                      ACCEPT,
  output logic [PC_W-1:0]           VECTOR,
  output logic                      RETURN_VALID,
  output logic [PC_W-1:0]           RETURN_PC,
  output logic                      HALTED,
  output logic                      RESUME,
  // Request sources and key pins
  input  wire logic                 TIMER8_REQ,
  input  wire logic                 INTERVAL_REQ,
  input  wire logic                 EXT_PIN,
  input  wire logic [3:0]           KEY_A,
  input  wire logic [3:0]           KEY_B
);
  import ihc_pkg::*;

  localparam int SP_W = $clog2(STACK_DEPTH + 1);

  if (STACK_DEPTH < 1 || STACK_DEPTH > 7 || PC_W < 4) begin : g_param_check
    $error("ihc_top: STACK_DEPTH must be 1..7 and PC_W at least 4");
  end

  function automatic logic [1:0] reg_index(input logic [3:0] addr);
    reg_index = addr[3:2];
  endfunction

  function automatic logic [PC_W-1:0] vector_of(input logic [2:0] pend);
    logic [3:0] v;
    v = VEC_IVL;
    if (pend[SRC_PIN])
      v = VEC_PIN;
    if (pend[SRC_TMR8])
      v = VEC_TMR8;
    vector_of = PC_W'(v);
  endfunction

  function automatic logic [2:0] first_of(input logic [2:0] pend);
    first_of = 3'h0;
    if (pend[SRC_TMR8])
      first_of[SRC_TMR8] = 1'b1;
    else if (pend[SRC_PIN])
      first_of[SRC_PIN] = 1'b1;
    else if (pend[SRC_IVL])
      first_of[SRC_IVL] = 1'b1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave state.
  logic        aw_held;
  logic        w_held;
  logic [3:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        next_aw_held;
  logic        next_w_held;
  logic [3:0]  next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic        next_awready;
  logic        next_wready;
  logic [1:0]  next_bresp;
  logic        next_bvalid;
  logic        next_arready;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        next_rvalid;
  logic        wr_fire;

  // Controller state.
  logic                 edge_polarity_select;
  logic [2:0]           enable_flags;
  logic [2:0]           request_flags;
  logic                 pin_level;
  logic                 global_accept_flag;
  logic                 arm_wait;
  ihc_mode_e            mode;
  logic [PC_W-1:0]      halt_pc;
  logic [PC_W-1:0]      stack [STACK_DEPTH];
  logic [SP_W-1:0]      sp;
  logic                 next_edge;
  logic [2:0]           next_en;
  logic [2:0]           next_req;
  logic                 next_gaccept;
  logic                 next_arm;
  ihc_mode_e            next_mode;
  logic [PC_W-1:0]      next_halt_pc;
  logic [PC_W-1:0]      next_stack [STACK_DEPTH];
  logic [SP_W-1:0]      next_sp;
  logic                 next_accept;
  logic [PC_W-1:0]      next_vector;
  logic                 next_ret_valid;
  logic [PC_W-1:0]      next_ret_pc;
  logic                 next_resume;
  logic [2:0]           pending;
  logic [2:0]           hw_set;
  logic                 keys_low;
  logic                 take;
  logic [PC_W-1:0]      push_pc;

  assign pending  = request_flags & enable_flags;
  assign keys_low = ~&{KEY_A, KEY_B};
  assign wr_fire  = aw_held & w_held & ~BVALID;

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: address and data are taken in either order, then answered.
  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bresp   = BRESP;
    next_bvalid  = BVALID;
    next_rdata   = RDATA;
    next_rresp   = RRESP;
    next_rvalid  = RVALID;
    if (AWVALID && AWREADY)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = AWADDR;
    end
    if (WVALID && WREADY)
    begin
      next_w_held = 1'b1;
      next_w_data = WDATA;
      next_w_strb = WSTRB;
    end
    if (BVALID && BREADY)
      next_bvalid = 1'b0;
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (reg_index(aw_addr) == IDX_CTRL || reg_index(aw_addr) == IDX_REQ ||
                      reg_index(aw_addr) == IDX_STATUS) ? RESP_OKAY : RESP_SLVERR;
    end
    if (RVALID && RREADY)
      next_rvalid = 1'b0;
    if (ARVALID && ARREADY)
    begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      case (reg_index(ARADDR))
        IDX_CTRL:   next_rdata = {28'h0, enable_flags, edge_polarity_select};
        IDX_REQ:    next_rdata = {29'h0, request_flags};
        IDX_STATUS: next_rdata = {30'h0, HALTED, pin_level};
        default:
        begin
          next_rdata = 32'h0;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
    next_awready = ~next_aw_held & ~next_bvalid;
    next_wready  = ~next_w_held & ~next_bvalid;
    next_arready = ~next_rvalid;
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 4'h0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
      AWREADY <= 1'b0;
      WREADY  <= 1'b0;
      BRESP   <= RESP_OKAY;
      BVALID  <= 1'b0;
      ARREADY <= 1'b0;
      RDATA   <= 32'h0;
      RRESP   <= RESP_OKAY;
      RVALID  <= 1'b0;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      AWREADY <= next_awready;
      WREADY  <= next_wready;
      BRESP   <= next_bresp;
      BVALID  <= next_bvalid;
      ARREADY <= next_arready;
      RDATA   <= next_rdata;
      RRESP   <= next_rresp;
      RVALID  <= next_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Request flags, acceptance, return stack and pause control.
  always_comb
  begin
    next_edge      = edge_polarity_select;
    next_en        = enable_flags;
    next_req       = request_flags;
    next_gaccept   = global_accept_flag;
    next_arm       = arm_wait;
    next_mode      = mode;
    next_halt_pc   = halt_pc;
    next_stack     = stack;
    next_sp        = sp;
    next_accept    = 1'b0;
    next_vector    = VECTOR;
    next_ret_valid = 1'b0;
    next_ret_pc    = RETURN_PC;
    next_resume    = 1'b0;
    take           = 1'b0;
    push_pc        = NEXT_PC;
    hw_set         = 3'h0;
    hw_set[SRC_TMR8] = TIMER8_REQ;
    hw_set[SRC_IVL]  = INTERVAL_REQ;
    hw_set[SRC_PIN]  = edge_polarity_select ? (~EXT_PIN & pin_level)
                                            : (EXT_PIN & ~pin_level);
    if (wr_fire && w_strb[0])
    begin
      if (reg_index(aw_addr) == IDX_CTRL)
      begin
        next_edge = w_data[CTRL_EDGE_BIT];
        next_en   = w_data[CTRL_EN_LSB +: 3];
      end
      if (reg_index(aw_addr) == IDX_REQ)
        next_req = w_data[2:0];
    end
    case (mode)
      MODE_RUN:
      begin
        if (INSTR_END)
        begin
          // The instruction after an unmask has now ended, so the flag opens.
          if (arm_wait)
          begin
            next_gaccept = 1'b1;
            next_arm     = 1'b0;
          end
          case (INSTR_OP)
            OP_UNMASK:
              next_arm = 1'b1;
            OP_MASK:
            begin
              next_gaccept = 1'b0;
              next_arm     = 1'b0;
            end
            OP_RETURN:
            begin
              if (sp != '0)
              begin
                next_ret_pc = stack[sp - SP_W'(1)];
                next_sp     = sp - SP_W'(1);
              end
              next_ret_valid = 1'b1;
            end
            OP_HALT:
            begin
              if (HALT_OPND == OPND_TIMER && !request_flags[SRC_TMR8])
                next_mode = MODE_HALT_TMR;
              else if (HALT_OPND == OPND_ANY && pending == 3'h0 && !keys_low)
                next_mode = MODE_HALT_ANY;
              // Any other operand or unmet condition falls through as no-op.
              next_halt_pc = NEXT_PC;
            end
            default:
            begin
              // Accept only at the end of a completed instruction, never mid pair.
              if (!INSTR_TWO && global_accept_flag && pending != 3'h0)
                take = 1'b1;
            end
          endcase
        end
      end
      MODE_HALT_TMR:
      begin
        push_pc = halt_pc;
        if (request_flags[SRC_TMR8])
        begin
          next_mode = MODE_RUN;
          if (global_accept_flag && enable_flags[SRC_TMR8])
            take = 1'b1;
          else
            next_resume = 1'b1;
        end
      end
      MODE_HALT_ANY:
      begin
        push_pc = halt_pc;
        if (keys_low)
        begin
          next_mode   = MODE_RUN;
          next_resume = 1'b1;
        end
        else if (pending != 3'h0)
        begin
          next_mode = MODE_RUN;
          if (global_accept_flag)
            take = 1'b1;
          else
            next_resume = 1'b1;
        end
      end
      default:
        next_mode = MODE_RUN;
    endcase
    if (take)
    begin
      next_req     = next_req & ~first_of(pending);
      next_gaccept = 1'b0;
      next_arm     = 1'b0;
      next_vector  = vector_of(pending);
      next_accept  = 1'b1;
      if (sp != SP_W'(STACK_DEPTH))
      begin
        next_stack[sp] = push_pc;
        next_sp        = sp + SP_W'(1);
      end
    end
    // A hardware request landing with a clear still sets the flag.
    next_req = next_req | hw_set;
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      edge_polarity_select <= RST_EDGE;
      enable_flags         <= RST_EN;
      request_flags        <= RST_REQ;
      pin_level            <= 1'b0;
      global_accept_flag   <= 1'b0;
      arm_wait             <= 1'b0;
      mode                 <= MODE_RUN;
      halt_pc              <= '0;
      stack                <= '{default: '0};
      sp                   <= '0;
      ACCEPT               <= 1'b0;
      VECTOR               <= '0;
      RETURN_VALID         <= 1'b0;
      RETURN_PC            <= '0;
      HALTED               <= 1'b0;
      RESUME               <= 1'b0;
    end
    else
    begin
      edge_polarity_select <= next_edge;
      enable_flags         <= next_en;
      request_flags        <= next_req;
      pin_level            <= EXT_PIN;
      global_accept_flag   <= next_gaccept;
      arm_wait             <= next_arm;
      mode                 <= next_mode;
      halt_pc              <= next_halt_pc;
      stack                <= next_stack;
      sp                   <= next_sp;
      ACCEPT               <= next_accept;
      VECTOR               <= next_vector;
      RETURN_VALID         <= next_ret_valid;
      RETURN_PC            <= next_ret_pc;
      HALTED               <= (next_mode != MODE_RUN);
      RESUME               <= next_resume;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  pin_mirror_a: assert property (1 |=> pin_level == $past(EXT_PIN))
    else $error("pin level flag does not follow the pin");
  rise_edge_a: assert property ((!edge_polarity_select && EXT_PIN && !pin_level)
    |=> request_flags[SRC_PIN])
    else $error("rising pin edge did not set the request");
  timer_set_a: assert property (TIMER8_REQ |=> request_flags[SRC_TMR8])
    else $error("timer request was lost");
  accept_cause_a: assert property (ACCEPT |-> $past(pending) != 3'h0 && !global_accept_flag)
    else $error("acceptance without an enabled pending request");
  prio_order_a: assert property ((ACCEPT && VECTOR == PC_W'(VEC_PIN))
    |-> !$past(pending[SRC_TMR8]))
    else $error("lower priority accepted over timer");
  two_cycle_a: assert property ((INSTR_END && INSTR_TWO && mode == MODE_RUN) |=> !ACCEPT)
    else $error("request accepted inside a two-cycle instruction");
  unmask_delay_a: assert property ((INSTR_END && arm_wait && !global_accept_flag)
    |=> !ACCEPT)
    else $error("unmask took effect too early");
  timer_nop_a: assert property ((mode == MODE_RUN && INSTR_END && INSTR_OP == OP_HALT
    && HALT_OPND == OPND_TIMER && request_flags[SRC_TMR8]) |=> !HALTED)
    else $error("timer pause entered with request pending");
  key_release_a: assert property ((mode == MODE_HALT_ANY && keys_low)
    |=> RESUME && !HALTED && !ACCEPT)
    else $error("key release did not resume at the next instruction");
  hold_pause_a: assert property ((mode == MODE_HALT_ANY && !keys_low && pending == 3'h0)
    |=> HALTED)
    else $error("pause ended without an enabled cause");

endmodule

// ==== hdl/ihc_pkg.sv ====
// Purpose: Shared constants and types for the interrupt and pause controller.
// Assumes: 32-bit AXI4-Lite register bus; one instruction-cycle strobe from the core.
// Notes:   Summary of operation follows.
//
// Summary of operation
// - Status bit mirrors the external request pin level.
// - Polarity flag picks rising or falling pin edge.
// - Each source has its own enable flag.
// - Request sets flag; acceptance clears it.
// - Software writes request flags: set or withdraw.
// - Service starts after the setting cycle ends.
// - Two-cycle instructions delay service past second cycle.
// - Disabled source stays pending, never serviced.
// - Highest priority pending source is serviced first.
// - Vectors: timer 3, pin 2, interval 1.
// - Hidden accept flag: unmask sets, mask/accept/reset clear.
// - Acceptance saves context and branches in one cycle.
// - Unmask takes effect after the following instruction.
// - Pause stops execution until operand condition met.
// - Operand 0010B releases on timer request only.
// - Operand 1000B releases on enabled request or key low.
// - Key release resumes at next instruction always.
// - Disabled request holds pause; masked enabled resumes.
// - Enabled request with accept flag set branches.
// - Timer release branches only if accepted and enabled.
// - Pause with unmet condition acts as no-operation.
// - Timer pause needs timer request flag clear.
// - Any-source pause needs no enabled request, keys high.
package ihc_pkg;

  // Register byte offsets.
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_REQ    = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;

  // Register index values (byte offset divided by four).
  localparam logic [1:0] IDX_CTRL   = OFS_CTRL[3:2];
  localparam logic [1:0] IDX_REQ    = OFS_REQ[3:2];
  localparam logic [1:0] IDX_STATUS = OFS_STATUS[3:2];

  // Source order inside request and enable vectors, highest priority first.
  localparam int SRC_TMR8 = 0;
  localparam int SRC_PIN  = 1;
  localparam int SRC_IVL  = 2;

  // Field positions: control holds polarity at bit 0, enables at bits 3..1.
  localparam int CTRL_EDGE_BIT = 0;
  localparam int CTRL_EN_LSB   = 1;
  localparam int STAT_PIN_BIT  = 0;
  localparam int STAT_HALT_BIT = 1;

  // Reset values.
  localparam logic       RST_EDGE = 1'b0;
  localparam logic [2:0] RST_EN   = 3'h0;
  localparam logic [2:0] RST_REQ  = 3'h0;

  // Vector addresses per source.
  localparam logic [3:0] VEC_TMR8 = 4'h3;
  localparam logic [3:0] VEC_PIN  = 4'h2;
  localparam logic [3:0] VEC_IVL  = 4'h1;

  // Pause operands.
  localparam logic [3:0] OPND_TIMER = 4'h2;
  localparam logic [3:0] OPND_ANY   = 4'h8;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_UNMASK,
    OP_MASK,
    OP_RETURN,
    OP_HALT,
    OP_TABLE
  } ihc_op_e;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_HALT_TMR,
    MODE_HALT_ANY
  } ihc_mode_e;

endpackage

// ==== bench/ihc_core_model.sv ====
// Purpose: Behavioural instruction sequencer that feeds the controller's core port.
// Assumes: One instruction ends per call; the sequencer stays frozen while paused.
// Notes:   Qualifiers are scrambled between instruction ends, as a real core may do.
`timescale 1ns/1ps
module ihc_core_model
#(
  parameter int PC_W = 12
)
(
  // Clock and pause status
  input  wire logic              clk,
  input  wire logic              halted,
  // Instruction stream
  output logic                   instr_end,
  output ihc_pkg::ihc_op_e       instr_op,
  output logic                   instr_two,
  output logic [3:0]             halt_opnd,
  output logic [PC_W-1:0]        next_pc
);
  import ihc_pkg::*;

  logic [PC_W-1:0] pc;
  logic            stuck;

  initial
  begin
    pc        = '0;
    stuck     = 1'b0;
    instr_end = 1'b0;
    instr_op  = OP_NONE;
    instr_two = 1'b0;
    halt_opnd = 4'h0;
    next_pc   = '1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // The program never unmasks right before a pause and never clears an enabled flag
  // right before a pause; the bench's call order keeps that.
  task automatic instr(input ihc_op_e op, input logic two, input logic [3:0] opnd);
    int i;
    @(posedge clk);
    // Nothing executes while paused, so the next end waits for the release.
    for (i = 0; i < 200 && halted === 1'b1; i++)
      @(posedge clk);
    // A pause that never ends is reported by the bench as a run-out wait.
    stuck = (halted === 1'b1);
    pc = pc + 1'b1;
    instr_end <= 1'b1;
    instr_op  <= op;
    instr_two <= two;
    halt_opnd <= opnd;
    next_pc   <= pc;
    @(posedge clk);
    instr_end <= 1'b0;
    instr_op  <= OP_NONE;
    instr_two <= ~two;
    halt_opnd <= ~opnd;
    next_pc   <= ~pc;
  endtask
endmodule

// ==== bench/test_interrupt_halt_control.sv ====
// Purpose: Self-checking bench for request, priority, acceptance and pause control.
// Assumes: Registers at 0x0 control, 0x4 requests, 0x8 status over AXI4-Lite.
// Notes:   Every wait is bounded; a bus or core-model wait that runs out ends the run, a rel wait does not.
`timescale 1ns/1ps
module test_interrupt_halt_control;
  import ihc_pkg::*;

  logic clk = 1'b0, nrst = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, key_a = 4'hf, key_b = 4'hf;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic timer8_req = 1'b0, interval_req = 1'b0, ext_pin = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, accept, return_valid, halted, resume;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [11:0] vector, return_pc, next_pc, ppc;
  logic instr_end, instr_two, acc, res, rv;
  ihc_op_e instr_op;
  logic [3:0] halt_opnd;
  int n_errors = 0, samples_checked = 0;

  initial
  begin
    forever #20 clk = ~clk;
  end

  ihc_top u_dut (
    .CLK(clk), .NRST(nrst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .INSTR_END(instr_end), .INSTR_OP(instr_op), .INSTR_TWO(instr_two),
    .HALT_OPND(halt_opnd), .NEXT_PC(next_pc), .ACCEPT(accept), .VECTOR(vector),
    .RETURN_VALID(return_valid), .RETURN_PC(return_pc), .HALTED(halted),
    .RESUME(resume), .TIMER8_REQ(timer8_req), .INTERVAL_REQ(interval_req),
    .EXT_PIN(ext_pin), .KEY_A(key_a), .KEY_B(key_b)
  );

  ihc_core_model u_core (
    .clk(clk), .halted(halted), .instr_end(instr_end), .instr_op(instr_op),
    .instr_two(instr_two), .halt_opnd(halt_opnd), .next_pc(next_pc)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task tmo(input int i);
    if (i >= 50)
    begin
      n_errors++;
      $display("BAD %0t wait ran out", $time);
      conclude;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    int i;
    logic aw, w, b;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50 && (aw || w); i++)
    begin
      @(posedge clk);
      if (aw && awready === 1'b1)
      begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1)
      begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    tmo(i);
    for (i = 0; i < 50 && !b; i++)
    begin
      @(posedge clk);
      if (bvalid === 1'b1)
      begin
        b = 1'b1;
        bready <= 1'b0;
        check(bresp, er);
      end
    end
    tmo(i);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
    int i;
    logic t;
    t = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50 && !t; i++)
    begin
      @(posedge clk);
      if (arready === 1'b1)
      begin
        t = 1'b1;
        arvalid <= 1'b0;
      end
    end
    tmo(i);
    t = 1'b0;
    for (i = 0; i < 50 && !t; i++)
    begin
      @(posedge clk);
      if (rvalid === 1'b1)
      begin
        t = 1'b1;
        rready <= 1'b0;
        check(rdata, exp);
        check(rresp, er);
      end
    end
    tmo(i);
  endtask

  // Outputs answer one edge after the instruction end, so they are read just after it.
  task automatic ex(input ihc_op_e op, input logic two = 1'b0, input logic [3:0] opnd = 4'h0);
    u_core.instr(op, two, opnd);
    if (u_core.stuck)
      tmo(50);
    #1;
    acc = accept;
    res = resume;
    rv = return_valid;
  endtask

  task automatic pt(input logic t8);
    @(posedge clk);
    timer8_req <= t8;
    interval_req <= ~t8;
    @(posedge clk);
    timer8_req <= 1'b0;
    interval_req <= 1'b0;
  endtask

  task automatic rel(input int n);
    int i;
    acc = 1'b0;
    res = 1'b0;
    for (i = 0; i < n && !(acc || res); i++)
    begin
      @(posedge clk);
      #1;
      acc = accept;
      res = resume;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task t_regs;
    rd(OFS_CTRL, 32'h0);
    rd(OFS_REQ, 32'h0);
    rd(OFS_STATUS, 32'h0);
    rd(4'hc, 32'h0, RESP_SLVERR);
    wr(4'hc, 32'h0, RESP_SLVERR);
    $display("done registers");
  endtask

  task t_pin;
    @(posedge clk) ext_pin <= 1'b1;
    rd(OFS_STATUS, 32'h1);
    rd(OFS_REQ, 32'h2);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_REQ, 32'h0);
    @(posedge clk) ext_pin <= 1'b0;
    rd(OFS_STATUS, 32'h0);
    rd(OFS_REQ, 32'h2);
    wr(OFS_REQ, 32'h0);
    @(posedge clk) ext_pin <= 1'b1;
    rd(OFS_REQ, 32'h0);
    wr(OFS_CTRL, 32'h0);
    @(posedge clk) ext_pin <= 1'b0;
    rd(OFS_REQ, 32'h0);
    $display("done pin edges");
  endtask

  task t_soft;
    wr(OFS_REQ, 32'h5);
    rd(OFS_REQ, 32'h5);
    wr(OFS_REQ, 32'h0);
    rd(OFS_REQ, 32'h0);
    $display("done software requests");
  endtask

  task t_accept;
    wr(OFS_CTRL, 32'h6);
    rd(OFS_CTRL, 32'h6);
    wr(OFS_REQ, 32'h6);
    ex(OP_UNMASK);
    ex(OP_NONE);
    check(acc, 1'b0);
    fork
      pt(1'b1);
      ex(OP_NONE);
    join
    ppc = u_core.pc;
    check(acc, 1'b1);
    check(vector, VEC_PIN);
    ex(OP_NONE);
    check(acc, 1'b0);
    ex(OP_UNMASK);
    ex(OP_RETURN);
    check(rv, 1'b1);
    check(return_pc, ppc);
    ex(OP_NONE, 1'b1);
    check(acc, 1'b0);
    ex(OP_NONE);
    check(acc, 1'b1);
    check(vector, VEC_TMR8);
    rd(OFS_REQ, 32'h4);
    ex(OP_RETURN);
    ex(OP_MASK);
    wr(OFS_CTRL, 32'h8);
    ex(OP_UNMASK);
    ex(OP_NONE);
    ex(OP_NONE);
    check(acc, 1'b1);
    check(vector, VEC_IVL);
    ex(OP_RETURN);
    $display("done acceptance");
  endtask

  task t_halt8;
    ex(OP_MASK);
    wr(OFS_CTRL, 32'h2);
    wr(OFS_REQ, 32'h0);
    @(posedge clk) key_a <= 4'he;
    ex(OP_HALT, 1'b0, OPND_ANY);
    check(halted, 1'b0);
    @(posedge clk) key_a <= 4'hf;
    wr(OFS_REQ, 32'h1);
    ex(OP_HALT, 1'b0, OPND_ANY);
    check(halted, 1'b0);
    wr(OFS_REQ, 32'h0);
    ex(OP_NONE);
    ex(OP_HALT, 1'b0, OPND_ANY);
    check(halted, 1'b1);
    pt(1'b0);
    rel(10);
    check(acc | res, 1'b0);
    check(halted, 1'b1);
    @(posedge clk) key_b <= 4'hb;
    rel(10);
    check(res, 1'b1);
    check(acc, 1'b0);
    @(posedge clk) key_b <= 4'hf;
    wr(OFS_REQ, 32'h0);
    ex(OP_NONE);
    ex(OP_HALT, 1'b0, OPND_ANY);
    pt(1'b1);
    rel(10);
    check(res, 1'b1);
    wr(OFS_REQ, 32'h0);
    ex(OP_UNMASK);
    ex(OP_NONE);
    ex(OP_HALT, 1'b0, OPND_ANY);
    check(halted, 1'b1);
    pt(1'b1);
    rel(10);
    check(acc, 1'b1);
    check(vector, VEC_TMR8);
    ex(OP_RETURN);
    $display("done pause any source");
  endtask

  task t_halt2;
    ex(OP_MASK);
    wr(OFS_CTRL, 32'h8);
    wr(OFS_REQ, 32'h1);
    ex(OP_HALT, 1'b0, OPND_TIMER);
    check(halted, 1'b0);
    wr(OFS_REQ, 32'h0);
    ex(OP_HALT, 1'b0, 4'h4);
    check(halted, 1'b0);
    ex(OP_HALT, 1'b0, OPND_TIMER);
    check(halted, 1'b1);
    pt(1'b0);
    rel(10);
    check(acc | res, 1'b0);
    pt(1'b1);
    rel(10);
    check(res, 1'b1);
    check(acc, 1'b0);
    wr(OFS_REQ, 32'h0);
    wr(OFS_CTRL, 32'h2);
    ex(OP_UNMASK);
    ex(OP_NONE);
    ex(OP_HALT, 1'b0, OPND_TIMER);
    pt(1'b1);
    rel(10);
    check(acc, 1'b1);
    check(vector, VEC_TMR8);
    ex(OP_RETURN);
    $display("done pause timer");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_regs;
    t_pin;
    t_soft;
    t_accept;
    t_halt8;
    t_halt2;
    conclude;
  end
endmodule
